// [design/scc_clock_control.sv]
// module: system and module clock control with an ahb-lite register port
// assumes: source ticks are one-cycle pulses made by same-clock edge
// detectors, one per rising edge of each oscillator; outputs are ticks
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module scc_clock_control
	import scc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        rcTick,
	input  wire logic        crystalTick,
	input  wire logic        doubledTick,
	output logic             sysTick,
	output logic             timerTick,
	output logic             usbTick,
	output logic             i2sTick,
	output logic             codecTick,
	output logic             crystalOutTick,
	output logic      [23:0] moduleTick
);
	// bus state
	logic [7:0]  addrIdx_r;
	logic        wrPend_r;
	logic [7:0]  rdData_r;
	logic        addrPhase;
	logic [7:0]  addrIdxNew;
	logic [7:0]  rdNxt;

	// register file
	logic [7:0]  regs_r [NREG];
	logic [7:0]  regs_nxt [NREG];
	logic [7:0]  statusVal;

	// decoded fields
	logic [1:0]  srcReq;
	logic [4:0]  sysDiv;
	logic [1:0]  hscReq;
	logic [23:0] enAll;

	// high-speed selection
	logic [1:0]  hscAct_r;
	logic        hscBlank_r;
	logic        hscOldTick;
	logic        hscSwitch;
	logic        hscTick;

	// high-speed divider
	logic [4:0]  hsCnt_r;
	logic [4:0]  hsDivL_r;
	logic        hsWrap;
	logic        hsTick;

	// system selection
	scc_src_type sysAct_r;
	logic        sysBlank_r;
	logic        sysOldTick;
	logic        sysSwitch;
	logic        sysTickNxt;
	logic        tick32;

	// output flops
	logic        sysTick_r;
	logic        usbTick_r;
	logic        xtalTick_r;
	logic [23:0] moduleTick_r;

	// pick the high-speed source tick for a selector value
	function automatic logic hsc_pick(input logic [1:0] sel,
		input logic dbl, input logic rc, input logic xtal);
		logic r;
		r = sel[1] ? xtal : (sel[0] ? rc : dbl);
		return r;
	endfunction

	// pick the system source tick for a selector value
	function automatic logic sys_pick(input scc_src_type sel,
		input logic rc, input logic hsc, input logic hs,
		input logic t32);
		logic r;
		unique case (sel)
			SRC_RC:    r = rc;
			SRC_HSC:   r = hsc;
			SRC_HSDIV: r = hs;
			SRC_32M:   r = t32;
		endcase
		return r;
	endfunction

	// address phase decode; data phase never stretched
	assign addrPhase = hsel && htrans[1] && hready;
	assign addrIdxNew = scc_word(haddr);
	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = {24'h0, rdData_r};

	// writes land in the data phase from the low byte lane
	always_comb
	begin
		for (int i = 0; i < NREG; i++)
			regs_nxt[i] = (wrPend_r && addrIdx_r == REG_IDX[i]) ?
				hwdata[7:0] : regs_r[i];
	end

	// read data from next values so a write just before is seen
	always_comb
	begin
		rdNxt = 8'h00;
		for (int i = 0; i < NREG; i++)
			if (addrIdxNew == REG_IDX[i])
				rdNxt = regs_nxt[i];
		if (addrIdxNew == IDX_STATUS)
			rdNxt = statusVal;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			addrIdx_r <= IDX_NONE;
			wrPend_r <= 1'h0;
			rdData_r <= 8'h00;
		end
		else
		begin
			addrIdx_r <= addrPhase ? addrIdxNew : IDX_NONE;
			wrPend_r <= addrPhase && hwrite;
			if (addrPhase && !hwrite)
				rdData_r <= rdNxt;
		end
	end

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < NREG; i++)
			regs_r[i] <= rst ? REG_RST[i] : regs_nxt[i];
	end

	// field decode
	assign srcReq = regs_r[SLOT_SYS][SRC_MSB:SRC_LSB];
	assign sysDiv = regs_r[SLOT_SYS][DIV_MSB:0];
	assign hscReq = {regs_r[SLOT_HSC][HSC_HI_BIT],
		regs_r[SLOT_SYS][HSC_LO_BIT]};
	assign enAll = {regs_r[SLOT_EN_C], regs_r[SLOT_EN_B],
		regs_r[SLOT_EN_A]};
	assign statusVal = {3'h0, (sysAct_r != scc_src_type'(srcReq)) ||
		(hscAct_r != hscReq), hscAct_r, sysAct_r};

	// high-speed mux: change right after an old edge, then swallow the
	// first new edge so no period is shorter than either source's.
	// a stopped old source holds the switch; the trade is no runt pulse
	assign hscOldTick = hsc_pick(hscAct_r, doubledTick, rcTick,
		crystalTick);
	assign hscSwitch = (hscAct_r != hscReq) && hscOldTick && !hscBlank_r;
	assign hscTick = hscOldTick && !hscBlank_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hscAct_r <= 2'h0;
			hscBlank_r <= 1'h0;
		end
		else if (hscSwitch)
		begin
			hscAct_r <= hscReq;
			hscBlank_r <= 1'h1;
		end
		else if (hscOldTick)
			hscBlank_r <= 1'h0;
	end

	// integer divider; new value taken only at the wrap
	assign hsWrap = hsCnt_r >= hsDivL_r - 5'h1;
	assign hsTick = hscTick && hsWrap;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hsCnt_r <= 5'h0;
			hsDivL_r <= RST_SYS[DIV_MSB:0];
		end
		else if (hscTick)
		begin
			hsCnt_r <= hsWrap ? 5'h0 : hsCnt_r + 5'h1;
			if (hsWrap)
				hsDivL_r <= sysDiv;
		end
	end

	// fixed and programmable fractional dividers
	scc_div_if thirdsIf ();
	scc_div_if timerIf ();
	scc_div_if i2sIf ();
	scc_div_if codecIf ();

	// 32 MHz from 48 MHz through two thirds
	assign thirdsIf.en = 1'h1;
	assign thirdsIf.step = THIRDS_STEP;
	assign thirdsIf.modulus = THIRDS_MOD;
	assign thirdsIf.srcTick = doubledTick;
	assign tick32 = thirdsIf.outTick;

	// 16 MHz timer from the crystal; no register reaches it
	assign timerIf.en = 1'h1;
	assign timerIf.step = THIRDS_STEP;
	assign timerIf.modulus = THIRDS_MOD;
	assign timerIf.srcTick = crystalTick;
	assign timerTick = timerIf.outTick;

	// i2s from 48 MHz, gated by its enable bit
	assign i2sIf.en = regs_r[SLOT_I2S][EN_BIT];
	assign i2sIf.step = regs_r[SLOT_I2S][STEP_MSB:0];
	assign i2sIf.modulus = regs_r[SLOT_I2S_MOD];
	assign i2sIf.srcTick = doubledTick;
	assign i2sTick = i2sIf.outTick;

	// codec from 48 MHz, gated by its enable bit
	assign codecIf.en = regs_r[SLOT_CDC][EN_BIT];
	assign codecIf.step = regs_r[SLOT_CDC][STEP_MSB:0];
	assign codecIf.modulus = regs_r[SLOT_CDC_MOD];
	assign codecIf.srcTick = doubledTick;
	assign codecTick = codecIf.outTick;

	scc_frac_div #(.ACC_W(9)) uThirds (
		.clock (clock),
		.rst   (rst),
		.dv    (thirdsIf.div)
	);
	scc_frac_div #(.ACC_W(9)) uTimer (
		.clock (clock),
		.rst   (rst),
		.dv    (timerIf.div)
	);
	scc_frac_div #(.ACC_W(9)) uI2s (
		.clock (clock),
		.rst   (rst),
		.dv    (i2sIf.div)
	);
	scc_frac_div #(.ACC_W(9)) uCodec (
		.clock (clock),
		.rst   (rst),
		.dv    (codecIf.div)
	);

	// system mux, same switch-and-swallow scheme as the high-speed one
	assign sysOldTick = sys_pick(sysAct_r, rcTick, hscTick, hsTick,
		tick32);
	assign sysSwitch = (sysAct_r != scc_src_type'(srcReq)) &&
		sysOldTick && !sysBlank_r;
	assign sysTickNxt = sysOldTick && !sysBlank_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sysAct_r <= SRC_RC;
			sysBlank_r <= 1'h0;
		end
		else if (sysSwitch)
		begin
			sysAct_r <= scc_src_type'(srcReq);
			sysBlank_r <= 1'h1;
		end
		else if (sysOldTick)
			sysBlank_r <= 1'h0;
	end

	// registered tick outputs
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sysTick_r <= 1'h0;
			usbTick_r <= 1'h0;
			xtalTick_r <= 1'h0;
			moduleTick_r <= 24'h0;
		end
		else
		begin
			sysTick_r <= sysTickNxt;
			usbTick_r <= doubledTick;
			xtalTick_r <= crystalTick;
			moduleTick_r <= {24{sysTickNxt}} & enAll;
		end
	end

	assign sysTick = sysTick_r;
	assign usbTick = usbTick_r;
	assign crystalOutTick = xtalTick_r;
	assign moduleTick = moduleTick_r;

	// helper: high-speed edges since the last divided edge
	logic [4:0] hsGap_r;
	always_ff @(posedge clock)
	begin
		if (rst || hsTick)
			hsGap_r <= 5'h0;
		else if (hscTick)
			hsGap_r <= hsGap_r + 5'h1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_rc_pass;
		(sysAct_r == SRC_RC && !sysBlank_r && rcTick) |=> sysTick_r;
	endproperty
	a_rc_pass: assert property (p_rc_pass)
		else $error("rc edge not passed to system clock");

	property p_hs_ratio;
		hsTick |-> hsGap_r == hsDivL_r - 5'h1;
	endproperty
	a_hs_ratio: assert property (p_hs_ratio)
		else $error("divided clock spacing wrong");

	property p_hsc_rc;
		(hscAct_r == 2'b01 && !hscBlank_r && rcTick) |-> hscTick;
	endproperty
	a_hsc_rc: assert property (p_hsc_rc)
		else $error("high-speed rc edge lost");

	property p_hsc_xtal;
		(hscAct_r[1] && !hscBlank_r && crystalTick) |-> hscTick;
	endproperty
	a_hsc_xtal: assert property (p_hsc_xtal)
		else $error("high-speed crystal edge lost");

	property p_gate;
		sysTick_r ? moduleTick_r == $past(enAll) : moduleTick_r == 24'h0;
	endproperty
	a_gate: assert property (p_gate)
		else $error("module gating wrong");

	property p_usb;
		doubledTick |=> usbTick_r;
	endproperty
	a_usb: assert property (p_usb)
		else $error("usb edge lost");

	// a switch follows an old edge, then the first new edge is dropped
	sequence s_switch;
		$changed(sysAct_r) && $past(sysTickNxt);
	endsequence
	sequence s_swallow;
		sysBlank_r && !sysTickNxt;
	endsequence
	property p_switch;
		$changed(sysAct_r) |-> s_switch ##0 s_swallow;
	endproperty
	a_switch: assert property (p_switch)
		else $error("system source switched off an edge");

	property p_src_follows;
		(sysAct_r != scc_src_type'(srcReq) && sysTickNxt)
			|=> sysAct_r == $past(scc_src_type'(srcReq));
	endproperty
	a_src_follows: assert property (p_src_follows)
		else $error("system source request not taken");
endmodule

// [design/scc_pkg.sv]
// package: register map, fields and codes of the clock control block
// assumes: imported by the top module and by its fractional dividers
package scc_pkg;
	// register slots and word indices (byte address is four times index)
	localparam int NREG = 9;
	localparam int SLOT_EN_A = 0;
	localparam int SLOT_EN_B = 1;
	localparam int SLOT_EN_C = 2;
	localparam int SLOT_SYS = 3;
	localparam int SLOT_I2S = 4;
	localparam int SLOT_I2S_MOD = 5;
	localparam int SLOT_CDC = 6;
	localparam int SLOT_CDC_MOD = 7;
	localparam int SLOT_HSC = 8;
	localparam logic [7:0] IDX_EN_A = 8'h63;
	localparam logic [7:0] IDX_EN_B = 8'h64;
	localparam logic [7:0] IDX_EN_C = 8'h65;
	localparam logic [7:0] IDX_SYS = 8'h66;
	localparam logic [7:0] IDX_I2S = 8'h67;
	localparam logic [7:0] IDX_I2S_MOD = 8'h68;
	localparam logic [7:0] IDX_CDC = 8'h6c;
	localparam logic [7:0] IDX_CDC_MOD = 8'h6d;
	localparam logic [7:0] IDX_HSC = 8'h70;
	localparam logic [7:0] IDX_STATUS = 8'h74;
	localparam logic [7:0] IDX_NONE = 8'hff;
	localparam logic [7:0] REG_IDX [NREG] = '{IDX_EN_A, IDX_EN_B,
		IDX_EN_C, IDX_SYS, IDX_I2S, IDX_I2S_MOD, IDX_CDC, IDX_CDC_MOD,
		IDX_HSC};
	// reset values
	localparam logic [7:0] RST_EN_A = 8'h83;
	localparam logic [7:0] RST_EN_B = 8'h00;
	localparam logic [7:0] RST_EN_C = 8'h30;
	localparam logic [7:0] RST_SYS = 8'h06;
	localparam logic [7:0] RST_I2S = 8'h00;
	localparam logic [7:0] RST_I2S_MOD = 8'h02;
	localparam logic [7:0] RST_CDC = 8'h01;
	localparam logic [7:0] RST_CDC_MOD = 8'h02;
	localparam logic [7:0] RST_HSC = 8'h00;
	localparam logic [7:0] REG_RST [NREG] = '{RST_EN_A, RST_EN_B,
		RST_EN_C, RST_SYS, RST_I2S, RST_I2S_MOD, RST_CDC, RST_CDC_MOD,
		RST_HSC};
	// field positions
	localparam int SRC_LSB = 5;
	localparam int SRC_MSB = 6;
	localparam int DIV_MSB = 4;
	localparam int HSC_LO_BIT = 7;
	localparam int HSC_HI_BIT = 0;
	localparam int EN_BIT = 7;
	localparam int STEP_MSB = 6;
	// fixed two-thirds divider
	localparam logic [6:0] THIRDS_STEP = 7'h02;
	localparam logic [7:0] THIRDS_MOD = 8'h03;
	typedef enum logic [1:0] {
		SRC_RC = 2'b00,
		SRC_HSC = 2'b01,
		SRC_HSDIV = 2'b10,
		SRC_32M = 2'b11
	} scc_src_type;
	// word index of a bus address, IDX_NONE outside the block window
	function automatic logic [7:0] scc_word(input logic [31:0] a);
		return (a[31:10] == 22'h0) ? a[9:2] : IDX_NONE;
	endfunction
endpackage

// [design/scc_div_if.sv]
// interface: settings and ticks between the top and a fractional divider
// assumes: all signals on the one system clock
`timescale 1ns/1ps
interface scc_div_if;
	logic       en;
	logic [6:0] step;
	logic [7:0] modulus;
	logic       srcTick;
	logic       outTick;
	modport ctl (output en, step, modulus, srcTick, input outTick);
	modport div (input en, step, modulus, srcTick, output outTick);
endinterface

// [design/scc_frac_div.sv]
// module: step/mod fractional divider on a tick stream
// assumes: source ticks are one-cycle pulses on the system clock
`timescale 1ns/1ps
module scc_frac_div
	import scc_pkg::*;
#(
	parameter int ACC_W = 9
)(
	input wire logic clock,
	input wire logic rst,
	scc_div_if.div   dv
);
	// accumulator must hold mod plus step without wrapping
	if (ACC_W < 9)
	begin : g_chk
		$error("scc_frac_div: ACC_W below 9");
	end

	logic [ACC_W-1:0] acc_r;
	logic [6:0]       stepL_r;
	logic [7:0]       modL_r;
	logic             tick_r;
	logic [ACC_W-1:0] sum;
	logic             wrap;
	logic             adv;

	// one output edge each time step accumulates to mod or past it
	assign sum = acc_r + ACC_W'(stepL_r);
	assign wrap = (sum >= ACC_W'(modL_r));
	assign adv = dv.en && dv.srcTick;
	assign dv.outTick = tick_r;

	// settings latched only at an output edge or while off: no runt
	always_ff @(posedge clock)
	begin
		if (rst || !dv.en)
		begin
			acc_r <= '0;
			tick_r <= 1'h0;
			stepL_r <= dv.step;
			modL_r <= dv.modulus;
		end
		else if (adv)
		begin
			acc_r <= wrap ? sum - ACC_W'(modL_r) : sum;
			tick_r <= wrap;
			if (wrap)
			begin
				stepL_r <= dv.step;
				modL_r <= dv.modulus;
			end
		end
		else
			tick_r <= 1'h0;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_off_silent;
		!dv.en |=> !tick_r;
	endproperty
	a_off_silent: assert property (p_off_silent)
		else $error("divider ticked while disabled");

	property p_tick_cause;
		tick_r |-> $past(adv) && $past(wrap);
	endproperty
	a_tick_cause: assert property (p_tick_cause)
		else $error("divider tick without source tick");

	property p_acc_bound;
		(dv.en && modL_r != 8'h0 && {stepL_r, 1'h0} <= modL_r)
			|-> acc_r < ACC_W'(modL_r);
	endproperty
	a_acc_bound: assert property (p_acc_bound)
		else $error("divider accumulator beyond mod");
endmodule

// [tb/scc_osc_model.sv]
// partner: oscillator tick sources that feed the clock control block
// assumes: one system clock; ticks are same-clock one-cycle pulses
`timescale 1ns/1ps
module scc_osc_model
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic run,
	output logic      rcTick,
	output logic      crystalTick,
	output logic      doubledTick
);
	logic [1:0] p4_r;
	logic [2:0] p5_r;

	// phase counters; rc period 5 so it never aliases the crystal
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			p4_r <= 2'h0;
			p5_r <= 3'h0;
		end
		else
		begin
			p4_r <= p4_r + 2'h1;
			p5_r <= (p5_r == 3'h4) ? 3'h0 : p5_r + 3'h1;
		end
	end

	// stopped sources stand still at zero
	always_ff @(posedge clock)
	begin
		doubledTick <= run & ~rst & p4_r[0]; // twice the crystal
		crystalTick <= run & ~rst & (p4_r == 2'h1);
		rcTick      <= run & ~rst & (p5_r == 3'h2);
	end
endmodule

// [tb/testbench.sv]
// testbench: register access and tick rates of the clock control block
// assumes: partner model makes the oscillator ticks, 100 MHz clock
`timescale 1ns/1ps
`define SCC_CHK(nm, e, g) \
	begin \
		testsRun++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("ERROR %s expected %0h seen %0h", nm, e, g); \
		end \
	end
module testbench
	import scc_pkg::*;
;
	logic        clock, rst, hsel, hwrite, hready, run;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, rcTick, crystalTick, doubledTick;
	logic        sysTick, timerTick, usbTick, i2sTick, codecTick;
	logic        crystalOutTick, counting;
	logic [23:0] moduleTick;
	int          mismatches, testsRun, cycles;
	int          cSys, cTim, cUsb, cI2s, cCdc, cXo, cRc, cXt, cDb;
	int          cMod [24];

	assign hready = hreadyout;

	scc_clock_control scc_clock_control_inst (.clock(clock), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rcTick(rcTick), .crystalTick(crystalTick),
		.doubledTick(doubledTick), .sysTick(sysTick),
		.timerTick(timerTick), .usbTick(usbTick), .i2sTick(i2sTick),
		.codecTick(codecTick), .crystalOutTick(crystalOutTick),
		.moduleTick(moduleTick));

	scc_osc_model scc_osc_model_inst (.clock(clock), .rst(rst),
		.run(run), .rcTick(rcTick), .crystalTick(crystalTick),
		.doubledTick(doubledTick));

	// clock and hang guard; the run needs about 22300 cycles
	always #5 clock = ~clock;
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			mismatches++;
			results();
		end
	end

	// tick counters, live only inside a measuring window
	always @(posedge clock)
	begin
		if (counting === 1'b1)
		begin
			cSys += (sysTick === 1'b1);
			cTim += (timerTick === 1'b1);
			cUsb += (usbTick === 1'b1);
			cI2s += (i2sTick === 1'b1);
			cCdc += (codecTick === 1'b1);
			cXo += (crystalOutTick === 1'b1);
			cRc += (rcTick === 1'b1);
			cXt += (crystalTick === 1'b1);
			cDb += (doubledTick === 1'b1);
			for (int i = 0; i < 24; i++)
				cMod[i] += (moduleTick[i] === 1'b1);
		end
	end

	task automatic results();
		if (mismatches == 0 && testsRun > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one single write; entered just after a rising edge
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clock); while (hready !== 1'b1);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
	endtask

	// settle past a pending switch: the slowest old source (divider 31)
	// ticks only every 62 cycles, then count 1200 edges
	task automatic meas();
		repeat (100) @(posedge clock);
		@(negedge clock);
		{cSys, cTim, cUsb, cI2s, cCdc, cXo, cRc, cXt, cDb} = '0;
		foreach (cMod[i])
			cMod[i] = 0;
		counting = 1'b1;
		repeat (1200) @(negedge clock);
		counting = 1'b0;
		@(posedge clock);
	endtask

	// rate compare with one tick of slack for window edges
	task automatic near(input string nm, input int e, input int g);
		`SCC_CHK(nm, e, ((g >= e - 1) && (g <= e + 1)) ? e : g)
	endtask

	task automatic t_regs();
		logic [7:0]  tab [9];
		logic [31:0] q;
		tab = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02,
			8'h00};
		for (int i = 0; i < 9; i++)
		begin
			rd(REG_IDX[i], q);
			`SCC_CHK("reset value", {24'h0, tab[i]}, q)
		end
		for (int i = 0; i < 9; i++)
			wr(REG_IDX[i], 8'h40 + 8'(i)); // divider 3, mods large
		for (int i = 0; i < 9; i++)
		begin
			rd(REG_IDX[i], q);
			`SCC_CHK("readback", 32'h40 + 32'(i), q)
		end
		wr(8'h7f, 8'hff);
		rd(8'h7f, q);
		`SCC_CHK("unmapped", 32'h0, q)
		`SCC_CHK("bus okay", 2'h2, {hreadyout, hresp})
	endtask

	task automatic t_src();
		int          e;
		logic [31:0] q;
		wr(IDX_HSC, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			wr(IDX_SYS, {1'b0, 2'(s), 5'h06});
			meas();
			e = (s == 0) ? cRc : (s == 1) ? cDb : (s == 2) ? cDb / 6 :
				cDb * 2 / 3;
			near("system tick", e, cSys);
			near("usb tick", cDb, cUsb);
			near("crystal out", cXt, cXo);
			near("timer tick", cXt * 2 / 3, cTim);
			rd(IDX_STATUS, q);
			`SCC_CHK("active source", 32'(s), q)
		end
	endtask

	task automatic t_div();
		logic [4:0] d [2];
		d = '{5'h02, 5'h1f};
		for (int i = 0; i < 2; i++)
		begin
			wr(IDX_SYS, {3'h2, d[i]}); // never zero or one
			meas();
			near("divided", cDb / int'(d[i]), cSys);
		end
	endtask

	task automatic t_hsc();
		int          e;
		logic [31:0] q;
		for (int k = 0; k < 4; k++)
		begin
			wr(IDX_HSC, {7'h0, 1'(k >> 1)});
			wr(IDX_SYS, {1'(k), 2'h1, 5'h06});
			meas();
			e = (k == 0) ? cDb : (k == 1) ? cRc : cXt;
			near("high speed", e, cSys);
			rd(IDX_STATUS, q);
			`SCC_CHK("active high speed", 32'(4 * k + 1), q)
		end
	endtask

	task automatic t_gate();
		logic [23:0] en;
		en = 24'h813ca5;
		wr(IDX_EN_A, en[7:0]);
		wr(IDX_EN_B, en[15:8]);
		wr(IDX_EN_C, en[23:16]);
		wr(IDX_SYS, 8'h00);
		meas();
		for (int i = 0; i < 24; i++)
			near("module tick", en[i] ? cSys : 0, cMod[i]);
	endtask

	task automatic t_frac();
		logic [7:0] idx;
		for (int u = 0; u < 2; u++)
		begin
			idx = u ? IDX_CDC : IDX_I2S;
			wr(u ? IDX_CDC_MOD : IDX_I2S_MOD, 8'h08);
			wr(idx, 8'h03);
			meas();
			near("disabled", 0, u ? cCdc : cI2s);
			wr(idx, 8'h83);
			meas();
			near("fraction", cDb * 3 / 8, u ? cCdc : cI2s);
			wr(idx, 8'h84);
			meas();
			near("half rate", cDb / 2, u ? cCdc : cI2s);
		end
	endtask

	// reset, then each scenario in turn
	initial
	begin
		{clock, hsel, hwrite, counting} = '0;
		{haddr, hwdata, htrans} = '0;
		{mismatches, testsRun, cycles} = '0;
		hsize = 3'h2;
		rst = 1'b1;
		run = 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_regs();
		t_src();
		t_div();
		t_hsc();
		t_gate();
		t_frac();
		results();
	end
endmodule
